// file: verilog/sadc_pkg.sv
// Shared constants and types for the converter control block.
// Assumes one 200 MHz clock that also serves as the conversion clock.
package sadc_pkg;
   // ==================================================
   // Data widths and codes
   localparam int RES_W = 8; // Result width
   localparam logic [7:0] HALF_SCALE = 8'h80; // DAC start code, MSB trial
   localparam logic [7:0] RESULT_RST = 8'h00; // Output latch after reset
   localparam logic [2:0] MSB_IDX = 3'h7; // First trial bit
   localparam logic [7:0] ONE_HOT0 = 8'h01; // Trial bit seed

   // ==================================================
   // Timing counts, in conversion clock edges
   localparam int ACQ_EDGES = 3; // Edges from start to hold
   localparam logic [1:0] ACQ_LAST = 2'(ACQ_EDGES - 1); // Last acquire count
   localparam int CMP_WAIT = 3; // Settle edges before each decision
   localparam logic [1:0] CMP_LAST = 2'(CMP_WAIT - 1); // Last settle count
   localparam int ROM_GUARD = 1; // Clock periods after end with no start
   localparam logic [1:0] ROM_GUARD_CNT = 2'(ROM_GUARD); // Guard load value

   // ==================================================
   // Pin synchroniser layout
   localparam int PIN_W = 4; // Synchronised pins
   localparam int PIN_CS = 0; // Select, active low
   localparam int PIN_RD = 1; // Read strobe, active low
   localparam int PIN_MODE = 2; // Mode strap
   localparam int PIN_CMP = 3; // Comparator decision
   localparam logic [3:0] SYNC_RST = 4'h7; // Strobes idle high, comparator low

   // ==================================================
   // State encodings
   typedef enum logic [1:0] {
      SADC_SAR_IDLE = 2'b00,
      SADC_SAR_SETTLE = 2'b01,
      SADC_SAR_DECIDE = 2'b10
   } sadc_sar_st_t;

   typedef enum logic [1:0] {
      SADC_IDLE = 2'b00,
      SADC_ACQ = 2'b01,
      SADC_CONV = 2'b10,
      SADC_HALT = 2'b11
   } sadc_ctl_st_t;
endpackage

// file: verilog/sadc_sar.sv
// Successive-approximation sequencer: DAC code, trial bits, final code.
// Assumes comp_hi is already synchronised to clk.
module sadc_sar
   import sadc_pkg::*;
(
   input wire logic clk, // Conversion clock
   input wire logic rst_n, // Async reset, active low
   input wire logic start, // One-cycle request to begin
   input wire logic comp_hi, // Input above DAC level
   output logic [sadc_pkg::RES_W-1:0] dac_code, // Code driven to the DAC
   output logic trial_start, // Pulse: new trial code loaded
   output logic done, // Pulse: final code valid
   output logic [sadc_pkg::RES_W-1:0] result // Final code
);
   import sadc_pkg::*;

   // ==================================================
   // State
   sadc_sar_st_t st_q; // Sequencer state
   logic [2:0] bit_q; // Bit under trial
   logic [1:0] wait_q; // Settle counter
   logic [7:0] code_q; // Approximation register
   logic [7:0] decided; // Code after this decision
   logic done_q; // Done pulse
   logic [7:0] res_q; // Final code

   // Keep the bit when input is above the DAC level
   assign decided = comp_hi ? code_q : (code_q & ~(ONE_HOT0 << bit_q));
   assign dac_code = code_q;
   assign done = done_q;
   assign result = res_q;
   // New trial code each start and after every decision but the last
   assign trial_start = (st_q == SADC_SAR_IDLE && start) ||
                        (st_q == SADC_SAR_DECIDE && bit_q != 3'h0);

   // Sequencing and counters
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= SADC_SAR_IDLE;
         bit_q <= MSB_IDX;
         wait_q <= 2'h0;
      end else begin
         case (st_q)
            SADC_SAR_IDLE: begin
               wait_q <= 2'h0;
               bit_q <= MSB_IDX;
               if (start) st_q <= SADC_SAR_SETTLE;
            end
            SADC_SAR_SETTLE: begin
               // Gives the DAC and the comparator sync time to settle
               wait_q <= wait_q + 2'h1;
               if (wait_q == CMP_LAST) st_q <= SADC_SAR_DECIDE;
            end
            SADC_SAR_DECIDE: begin
               wait_q <= 2'h0;
               // Eight decisions, MSB down to LSB
               if (bit_q == 3'h0) st_q <= SADC_SAR_IDLE;
               else begin
                  bit_q <= bit_q - 3'h1;
                  st_q <= SADC_SAR_SETTLE;
               end
            end
            default: st_q <= SADC_SAR_IDLE;
         endcase
      end
   end

   // Approximation register and DAC code
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         code_q <= HALF_SCALE;
      end else if (st_q == SADC_SAR_IDLE && start) begin
         code_q <= HALF_SCALE;
      end else if (st_q == SADC_SAR_DECIDE) begin
         if (bit_q == 3'h0) code_q <= HALF_SCALE;
         else code_q <= decided | (ONE_HOT0 << (bit_q - 3'h1));
      end
   end

   // Final code and done pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         res_q <= RESULT_RST;
         done_q <= 1'b0;
      end else begin
         done_q <= (st_q == SADC_SAR_DECIDE && bit_q == 3'h0);
         if (st_q == SADC_SAR_DECIDE && bit_q == 3'h0) res_q <= decided;
      end
   end

   // ==================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_half_start: assert property (
      st_q == SADC_SAR_IDLE && start |=> code_q == HALF_SCALE && bit_q == MSB_IDX)
      else $error("DAC not at half scale after start");
   a_bit_decide: assert property (
      st_q == SADC_SAR_DECIDE && bit_q != 3'h0 |=> code_q[$past(bit_q)] == $past(comp_hi))
      else $error("Trial bit not kept or dropped by comparator");
   a_next_trial: assert property (
      st_q == SADC_SAR_DECIDE && bit_q != 3'h0 |=> code_q[bit_q] && wait_q == 2'h0)
      else $error("Next lower trial bit not set");
   a_eight_cmp: assert property (
      st_q == SADC_SAR_IDLE && start |-> ##33 done_q)
      else $error("Conversion did not end after eight decisions");
   a_done_half: assert property (
      done_q |-> code_q == HALF_SCALE && st_q == SADC_SAR_IDLE)
      else $error("DAC not back at half scale at end");
   c_sar_done: cover property (done_q);
endmodule

// file: verilog/sadc_ctl.sv
// Bus-facing control of the 8-bit converter: strobes, busy, result port.
// Assumes pins are asynchronous to clk; clk stands in for the conversion
// clock, and each of its edges counts as one falling conversion edge.
// The testbench resolves the result port wires from result_port_oe.
// What this block does
// - Strobes ignored unless select is low
// - Select plus read: output data, start conversion
// - Mode low, multi-sample variant only: continuous conversions, strobes only read
// - Busy low from start until conversion end
// - DAC starts at half scale
// - Keep bit when input above DAC
// - Store bit, set next trial, load DAC
// - Eight decisions, then latch result
// - Result readable, DAC back to half scale
// - Hold once, or sample before each bit
// - Starting read returns previous result at once
// - Eight outputs, bit 7 is MSB
// - Hold on third edge after busy falls, sixth edge after strobes low
// - Read right after end: data, no start
// - Async read at end: defer latch, halt
module sadc_ctl
   import sadc_pkg::*;
#(
   parameter bit TRACK_HOLD = 1'b0 // 1: single hold variant, 0: multi-sample
) (
   input wire logic clk, // Conversion clock, 200 MHz
   input wire logic rst_n, // Async reset, active low
   input wire logic cs_n, // Chip select pin, active low
   input wire logic rd_n, // Read strobe pin, active low
   input wire logic mode, // Mode pin, low selects continuous in the multi-sample variant
   input wire logic comp_hi, // Comparator: input above DAC level
   output logic [sadc_pkg::RES_W-1:0] result_port_o, // Result port data
   output logic result_port_oe, // Result port drive enable
   output logic busy_n, // Busy, active low
   output logic [sadc_pkg::RES_W-1:0] dac_code, // Internal DAC code
   output logic th_hold, // Track/hold switch open
   output logic sample_p // Pulse: sample before a decision
);
   import sadc_pkg::*;

   // ==================================================
   // Pin synchronisers
   logic [PIN_W-1:0] pin_vec; // Raw pins
   logic [PIN_W-1:0] sync1_q; // First stage, read only by second
   logic [PIN_W-1:0] sync2_q; // Second stage, safe to use
   logic cs_s; // Synchronised select
   logic rd_s; // Synchronised read
   logic mode_s; // Synchronised mode
   logic comp_s; // Synchronised comparator

   assign pin_vec[PIN_CS] = cs_n;
   assign pin_vec[PIN_RD] = rd_n;
   assign pin_vec[PIN_MODE] = mode;
   assign pin_vec[PIN_CMP] = comp_hi;

   // Two flops per pin; costs two edges of latency on every strobe
   for (genvar g = 0; g < PIN_W; g++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            sync1_q[g] <= SYNC_RST[g];
            sync2_q[g] <= SYNC_RST[g];
         end else begin
            sync1_q[g] <= pin_vec[g];
            sync2_q[g] <= sync1_q[g];
         end
      end
   end

   assign cs_s = sync2_q[PIN_CS];
   assign rd_s = sync2_q[PIN_RD];
   assign mode_s = sync2_q[PIN_MODE];
   assign comp_s = sync2_q[PIN_CMP];

   // ==================================================
   // Strobe decode
   logic sel_act; // Select and read both low
   logic sel_prev_q; // Previous sel_act
   logic sel_rise; // Access just began
   logic async_mode; // Continuous conversions

   // Read is meaningless without select
   assign sel_act = !cs_s && !rd_s;
   assign sel_rise = sel_act && !sel_prev_q;
   // Only the multi-sample variant has a mode pin
   assign async_mode = !TRACK_HOLD && !mode_s;

   // Edge memory for access start
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) sel_prev_q <= 1'b0;
      else sel_prev_q <= sel_act;
   end

   // ==================================================
   // Conversion control
   sadc_ctl_st_t st_q; // Control state
   sadc_ctl_st_t st_d; // Next control state
   logic [1:0] acq_q; // Edges since start
   logic [1:0] guard_q; // Clocks left in no-start window
   logic sar_start; // Begin bit trials
   logic sar_done; // Final code ready
   logic sar_trial; // New trial loaded
   logic [7:0] sar_res; // Final code
   logic latch_en; // Update output latch
   logic busy_n_q; // Busy register
   logic [7:0] result_q; // Output latch
   logic hold_q; // Track/hold switch open
   logic sample_q; // Sample pulse register

   // Bit trials begin on the third edge after the start
   assign sar_start = (st_q == SADC_ACQ) && (acq_q == ACQ_LAST);

   // Latch at end, unless an async read is pending
   assign latch_en = (st_q == SADC_CONV && sar_done && !(async_mode && sel_act)) ||
                     (st_q == SADC_HALT && !sel_act);

   // Next state
   always_comb begin
      st_d = st_q;
      case (st_q)
         SADC_IDLE: begin
            // Continuous mode restarts by itself
            if (async_mode) st_d = SADC_ACQ;
            // Access start converts, except just after an end
            else if (sel_rise && guard_q == 2'h0) st_d = SADC_ACQ;
         end
         SADC_ACQ: begin
            if (sar_start) st_d = SADC_CONV;
         end
         SADC_CONV: begin
            // Strobes low at end in continuous mode freeze everything
            if (sar_done && async_mode && sel_act) st_d = SADC_HALT;
            else if (sar_done) st_d = SADC_IDLE;
         end
         SADC_HALT: begin
            // Released when either strobe rises
            if (!sel_act) st_d = SADC_IDLE;
         end
         default: st_d = SADC_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) st_q <= SADC_IDLE;
      else st_q <= st_d;
   end

   // Acquire edge counter, cleared outside acquisition
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) acq_q <= 2'h0;
      else if (st_q == SADC_ACQ) acq_q <= acq_q + 2'h1;
      else acq_q <= 2'h0;
   end

   // No-start window after each end; reads there only fetch data
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) guard_q <= 2'h0;
      else if (st_q != SADC_IDLE && st_d == SADC_IDLE) guard_q <= ROM_GUARD_CNT;
      else if (guard_q != 2'h0) guard_q <= guard_q - 2'h1;
   end

   // Busy framing, from the next state so it moves with it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) busy_n_q <= 1'b1;
      else busy_n_q <= !(st_d == SADC_ACQ || st_d == SADC_CONV);
   end

   // Output latch; reads in between see the previous result
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) result_q <= RESULT_RST;
      else if (latch_en) result_q <= sar_res;
   end

   // Track/hold: open at the third edge, closed again at end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) hold_q <= 1'b0;
      else if (TRACK_HOLD && sar_start) hold_q <= 1'b1;
      else if (sar_done) hold_q <= 1'b0;
   end

   // Multi-sample variant samples ahead of every decision
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) sample_q <= 1'b0;
      else sample_q <= !TRACK_HOLD && sar_trial;
   end

   // ==================================================
   // Bit sequencer
   sadc_sar u_sar (
      .clk(clk),
      .rst_n(rst_n),
      .start(sar_start),
      .comp_hi(comp_s),
      .dac_code(dac_code),
      .trial_start(sar_trial),
      .done(sar_done),
      .result(sar_res)
   );

   // ==================================================
   // Outputs
   // Data bits keep their order, bit 7 on the MSB line
   assign result_port_o = result_q;
   // Enable follows strobes only; a slow-memory host sees new data at end
   assign result_port_oe = sel_act;
   assign busy_n = busy_n_q;
   assign th_hold = hold_q;
   assign sample_p = sample_q;

   // ==================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_port_gated: assert property (
      result_port_oe |-> $past(cs_n, 2) == 1'b0 && $past(rd_n, 2) == 1'b0)
      else $error("Result port driven without both strobes low");
   a_sel_needed: assert property (
      $past(cs_n, 2) && st_q == SADC_IDLE && !async_mode |=> busy_n)
      else $error("Conversion started while deselected");
   a_read_starts: assert property (
      st_q == SADC_IDLE && !async_mode && sel_rise && guard_q == 2'h0 |=> $fell(busy_n))
      else $error("Read did not start a conversion");
   a_busy_frame: assert property (
      $fell(busy_n) |-> !busy_n [*8] ##29 $rose(busy_n))
      else $error("Busy low time wrong");
   a_hold_third: assert property (
      TRACK_HOLD && $fell(busy_n) |-> !th_hold [*3] ##1 th_hold)
      else $error("Hold not on third edge");
   a_rom_guard: assert property (
      st_q == SADC_IDLE && !async_mode && sel_rise && guard_q != 2'h0 |=> busy_n [*2])
      else $error("Conversion started inside guard window");
   a_async_halt: assert property (
      st_q == SADC_HALT && sel_act |=> busy_n && $stable(result_q))
      else $error("Halted conversion updated latch or dropped busy");
   a_async_cont: assert property (
      async_mode && st_q == SADC_IDLE |=> !busy_n)
      else $error("Continuous mode did not restart");
   a_old_data: assert property (
      $fell(busy_n) |=> $stable(result_q) [*8])
      else $error("Result changed early in conversion");

   c_rom_conv: cover property (!async_mode && $rose(busy_n) ##[1:20] sel_rise);
   c_guard_skip: cover property (st_q == SADC_IDLE && sel_rise && guard_q != 2'h0);
   c_halt: cover property (st_q == SADC_HALT ##1 st_q == SADC_IDLE);
   c_slow_mem: cover property (sel_act && latch_en);
endmodule

// file: test/sadc_host.sv
// Host side model: bus strobes, mode strap and the analog comparator.
// Assumes the bench calls its tasks and feeds it the DAC code it must compare.
module sadc_host (
   input wire logic clk, // Conversion clock
   input wire logic [7:0] dac_code, // DAC code from the block
   input wire logic [7:0] analog_input, // Input level, in DAC codes
   output logic cs_n, // Select, active low
   output logic rd_n, // Read strobe, active low
   output logic mode, // Mode strap, low for continuous
   output logic comp_hi // Comparator decision
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==================================================
   // Idle bus at time zero
   initial begin
      cs_n = 1'b1; // Deselected
      rd_n = 1'b1; // No read
      mode = 1'b1; // Strobe-started modes
      comp_hi = 1'b0; // Input low
   end

   // ==================================================
   // Comparator, changed off the sampling edge
   always @(negedge clk) begin
      comp_hi <= (analog_input > dac_code);
   end

   // Both strobes move at one falling edge; slow reads hold them until busy ends
   task pins(input logic c, input logic r);
      @(negedge clk);
      cs_n = c;
      rd_n = r;
   endtask

   // Strap changes only while the bus is idle
   task set_mode(input logic m);
      @(negedge clk);
      mode = m;
   endtask
endmodule

// file: test/sadc_ctl_test.sv
// Self-checking bench for the converter control block, both variants.
// Assumes the host model drives strobes and comparator at falling edges.
module sadc_ctl_test;
   import sadc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   // ==================================================
   // Signals
   logic clk = 1'b0; // 200 MHz clock
   logic rst_n = 1'b0; // Reset, active low
   logic [7:0] analog_input = 8'h00; // Input level
   logic cs_n, rd_n, mode, comp_hi; // Host outputs
   logic [7:0] result_port_o, dac_code, result_port, port_last; // Data
   logic result_port_oe, busy_n, th_hold, sample_p; // Multi-sample outputs
   logic th_busy_n, th_hold_2; // Track/hold variant outputs
   int error_cnt = 0; // Mismatches
   int num_checks = 0; // Comparisons
   int cyc = 0; // Cycle count for the timeout

   initial begin
      forever #2.5 clk = ~clk;
   end

   // ==================================================
   // Instances
   sadc_host sadc_host_inst (.clk(clk), .dac_code(dac_code), .analog_input(analog_input),
      .cs_n(cs_n), .rd_n(rd_n), .mode(mode), .comp_hi(comp_hi));
   sadc_ctl #(.TRACK_HOLD(1'b0)) sadc_ctl_inst (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n),
      .mode(mode), .comp_hi(comp_hi), .result_port_o(result_port_o), .result_port_oe(result_port_oe),
      .busy_n(busy_n), .dac_code(dac_code), .th_hold(th_hold), .sample_p(sample_p));
   // Second copy sees the same pins; mode is ignored there
   sadc_ctl #(.TRACK_HOLD(1'b1)) sadc_ctl_th_inst (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n),
      .mode(mode), .comp_hi(comp_hi), .result_port_o(), .result_port_oe(),
      .busy_n(th_busy_n), .dac_code(), .th_hold(th_hold_2), .sample_p());

   // Released port shows the inverse of its last value, never a stale copy
   always @(posedge clk) begin
      if (result_port_oe === 1'b1) port_last <= result_port_o;
   end
   assign result_port = (result_port_oe === 1'b1) ? result_port_o : ~port_last;

   // ==================================================
   // Shared tasks
   task check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask

   // Bounded wait for busy to reach a level
   task wait_busy(input logic lvl);
      int k;
      k = 0;
      while (busy_n !== lvl && k < 200) begin
         @(posedge clk);
         #1;
         k++;
      end
      check(8'(busy_n), 8'(lvl), "busy level not reached");
   endtask

   task cycles(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Reference approximation, bit by bit from the MSB
   function automatic logic [7:0] sar_ref(input logic [7:0] a);
      logic [7:0] c;
      c = 8'h00;
      for (int b = 7; b >= 0; b--) begin
         if (a > (c | (8'h01 << b))) c = c | (8'h01 << b);
      end
      return c;
   endfunction

   task final_report();
      if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // ==================================================
   // Scenarios
   task test_deselect();
      sadc_host_inst.pins(1'b1, 1'b0); // Read without select
      cycles(10);
      check(8'(result_port_oe), 8'h00, "port driven unselected");
      check(8'(busy_n), 8'h01, "start unselected");
      sadc_host_inst.pins(1'b1, 1'b1);
   endtask

   // Slow memory read: strobes held until busy rises, new data then shown
   task test_slow(input logic [7:0] a);
      int n, s;
      analog_input = a;
      sadc_host_inst.pins(1'b0, 1'b0);
      wait_busy(1'b0);
      check(dac_code, HALF_SCALE, "dac not half scale");
      n = 0;
      s = 0;
      while (busy_n === 1'b0 && n < 100) begin
         @(posedge clk);
         #1;
         n++;
         s += int'(sample_p === 1'b1);
         if (n == 20) check(8'(th_hold_2), 8'h01, "no hold mid conversion");
      end
      check(8'(n), 8'd36, "busy length");
      check(8'(s), 8'd8, "sample count");
      check(result_port, sar_ref(a), "slow read data");
      check(dac_code, HALF_SCALE, "dac not back to half");
      check(8'(th_hold_2), 8'h00, "hold after end");
      sadc_host_inst.pins(1'b1, 1'b1);
      cycles(3);
      check(8'(result_port_oe), 8'h00, "port still driven");
   endtask

   // ROM reads: old data at once, new data on the read after busy rises
   task test_rom(input logic [7:0] prev, input logic [7:0] a);
      analog_input = a;
      sadc_host_inst.pins(1'b0, 1'b0);
      cycles(3);
      check(8'(result_port_oe), 8'h01, "port not driven");
      check(result_port, prev, "rom old data");
      sadc_host_inst.pins(1'b1, 1'b1);
      wait_busy(1'b0);
      wait_busy(1'b1);
      cycles(3);
      sadc_host_inst.pins(1'b0, 1'b0);
      cycles(3);
      check(result_port, sar_ref(a), "rom new data");
      sadc_host_inst.pins(1'b1, 1'b1);
      wait_busy(1'b0);
      // Strobes seen low on the first cycle after the end, inside the guard window: data only
      repeat (33) @(negedge clk);
      sadc_host_inst.pins(1'b0, 1'b0);
      cycles(3);
      check(result_port, sar_ref(a), "guard read data");
      wait_busy(1'b1);
      cycles(2);
      check(8'(busy_n), 8'h01, "start inside guard window");
      sadc_host_inst.pins(1'b1, 1'b1);
   endtask

   // Continuous mode, with a read held across the end of a conversion
   task test_cont(input logic [7:0] a, input logic [7:0] b);
      analog_input = a;
      sadc_host_inst.set_mode(1'b0);
      wait_busy(1'b0);
      wait_busy(1'b1);
      analog_input = b;
      wait_busy(1'b0);
      cycles(10);
      sadc_host_inst.pins(1'b0, 1'b0);
      wait_busy(1'b1);
      cycles(10);
      check(8'(busy_n), 8'h01, "no halt while read held");
      check(result_port, sar_ref(a), "latch not deferred");
      sadc_host_inst.pins(1'b1, 1'b1);
      wait_busy(1'b0);
      sadc_host_inst.pins(1'b0, 1'b0);
      cycles(4);
      check(result_port, sar_ref(b), "deferred code lost");
      sadc_host_inst.pins(1'b1, 1'b1);
   endtask

   // ==================================================
   // Main sequence
   initial begin
      cycles(2);
      check(8'(busy_n), 8'h01, "busy in reset");
      check(8'(result_port_oe), 8'h00, "port in reset");
      check(dac_code, HALF_SCALE, "dac in reset");
      check(8'(th_hold_2), 8'h00, "hold in reset");
      cycles(2);
      @(negedge clk);
      rst_n = 1'b1;
      cycles(4);
      test_deselect();
      test_slow(8'hC5);
      test_rom(sar_ref(8'hC5), 8'h3A);
      test_cont(8'h81, 8'h5E);
      final_report();
   end

   // Hang guard, well above the few hundred cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         final_report();
      end
   end
endmodule
